// ==== verilog/prediction_pkg.sv ====
// constants, register map and types for the failure prediction block
package prediction_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MULT = 8'h04;
  localparam logic [7:0] OFS_TRAVEL = 8'h08;
  localparam logic [7:0] OFS_FR_AVG = 8'h0c;
  localparam logic [7:0] OFS_FR_STD = 8'h10;
  localparam logic [7:0] OFS_COEF_ONE = 8'h14;
  localparam logic [7:0] OFS_COEF_TWO = 8'h18;
  localparam logic [7:0] OFS_VB_AVG = 8'h1c;
  localparam logic [7:0] OFS_VB_STD = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  localparam logic [7:0] OFS_FR_UPPER = 8'h30;
  localparam logic [7:0] OFS_FR_LOWER = 8'h34;
  localparam logic [7:0] OFS_VB_UPPER = 8'h38;

  // ==========================================================
  // field positions
  localparam int CTRL_FR_SEL_LSB = 0;
  localparam int CTRL_VB_SEL_LSB = 4;
  localparam int CTRL_TRAVEL_SEL_LSB = 8;
  localparam int MULT_FR_LSB = 0;
  localparam int MULT_VB_LSB = 4;
  localparam int IRQ_FR_SET = 0;
  localparam int IRQ_FR_CLR = 1;
  localparam int IRQ_VB_SET = 2;
  localparam int IRQ_VB_CLR = 3;
  localparam int IRQ_FR_LEARNED = 4;
  localparam int IRQ_VB_LEARNED = 5;
  localparam int IRQ_BITS = 6;

  // ==========================================================
  // selection codes and reset values
  localparam logic [1:0] SEL_DISABLED = 2'h0;
  localparam logic [1:0] SEL_AUTO = 2'h1;
  localparam logic [1:0] SEL_MANUAL = 2'h2;
  localparam logic [1:0] SEL_RESET = 2'h3;
  localparam logic [3:0] MULT_DEFAULT = 4'h5;
  localparam logic [15:0] SETTING_RESET = 16'h0000;
  localparam int STD_SHIFT = 5;

  // ==========================================================
  // learning times
  localparam logic [1:0] LEARN_CONT_HOURS = 2'h3;
  localparam logic [6:0] LEARN_CUM_HOURS = 7'h5a;
  localparam longint HOUR_S = 3600;
  localparam longint CLK_HZ = 250000000;
  localparam logic [39:0] HOUR_CYCLES = 40'(HOUR_S * CLK_HZ);

  // drive operating mode
  typedef enum logic [1:0] {
    MODE_POSITION = 2'h0,
    MODE_VELOCITY = 2'h1,
    MODE_TORQUE = 2'h2
  } drive_mode_t;

endpackage : prediction_pkg

// ==== verilog/learn_if.sv ====
// learning timer hookup between the controller and its hour counters
interface learn_if;
  logic hour_tick;
  logic running;
  logic counting_mode;
  logic clear;
  logic ready;

  modport timer (input hour_tick, input running, input counting_mode, input clear,
    output ready);
  modport ctrl (output hour_tick, output running, output counting_mode, output clear,
    input ready);
endinterface : learn_if

// ==== verilog/learn_timer.sv ====
// continuous and cumulative operating hour counter for threshold learning
module learn_timer (
  input wire logic pclk,
  input wire logic presetn,
  learn_if.timer lk
);

  typedef struct packed {
    logic [1:0] cont;
    logic [6:0] cum;
  } timer_state_t;

  timer_state_t q;
  timer_state_t d;

  // ==========================================================
  // hour counting
  always_comb begin
    d = q;
    if (lk.clear) begin
      d = '0;
    end else begin
      if (!lk.running) begin
        d.cont = '0; // a stop breaks the continuous run
      end else if (lk.hour_tick && q.cont != prediction_pkg::LEARN_CONT_HOURS) begin
        d.cont = q.cont + 2'h1;
      end
      if (lk.hour_tick && lk.running && lk.counting_mode &&
          q.cum != prediction_pkg::LEARN_CUM_HOURS) begin
        d.cum = q.cum + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // both hour targets reached
  assign lk.ready = (q.cont == prediction_pkg::LEARN_CONT_HOURS) &&
                    (q.cum == prediction_pkg::LEARN_CUM_HOURS);

endmodule : learn_timer

// ==== verilog/limit_band.sv ====
// upper and lower limit from average, deviation and multiplier
module limit_band (
  input wire logic [15:0] average,
  input wire logic [15:0] std_dev,
  input wire logic [3:0] mult,
  output logic signed [21:0] upper,
  output logic signed [21:0] lower
);

  logic [3:0] eff_mult;
  logic [19:0] spread;

  // zero multiplier behaves as the default
  assign eff_mult = (mult == 4'h0) ? prediction_pkg::MULT_DEFAULT : mult; // [R11]
  assign spread = 20'(std_dev) * 20'(eff_mult);

  // band edges in 0.1 percent units, signed so the lower edge may go negative
  assign upper = $signed({6'h00, average}) + $signed({2'h0, spread});
  assign lower = $signed({6'h00, average}) - $signed({2'h0, spread});

endmodule : limit_band

// ==== verilog/friction_failure_predictor.sv ====
// friction and vibration failure prediction with apb register file
// Operation
// [R01] friction warning raised on rising or falling dynamic friction estimate
// [R02] no friction or vibration prediction while the drive is in torque mode
// [R03] friction learning after half travel span, 3 running and 90 pos/vel hours
// [R04] vibration learning needs 3 continuous and 90 pos/vel cumulative hours
// [R05] automatic mode never raises the friction warning before learning ends
// [R06] manual friction prediction starts once travel exceeds half the span
// [R07] selection codes: 0 disabled, 1 automatic, 2 manual, 3 reset
// [R08] automatic learning overwrites friction average and deviation settings
// [R09] after learning the friction selection becomes manual, code 2
// [R10] limits are average plus or minus deviation times multiplier
// [R11] multiplier zero acts as multiplier five
// [R12] warning raised when friction leaves the band above or below
// [R13] warning clears itself when friction returns inside the band
// [R14] selection 3 clears learned thresholds at power-up and becomes 1
// [R15] software raises multiplier to 6 or more after false warnings
// [R16] software loads learned coefficients when entering manual thresholds
// [R17] software enables vibration prediction only after gain tuning
// [R18] vibration warning raised when vibration level rises above threshold
// [R19] friction and vibration warnings are separate readable status flags
module friction_failure_predictor #(
  parameter logic [39:0] HOUR_CYCLES = prediction_pkg::HOUR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] friction_estimate,
  input wire logic friction_estimate_valid,
  input wire logic [15:0] vibration_level,
  input wire logic vibration_level_valid,
  input wire prediction_pkg::drive_mode_t drive_mode,
  input wire logic motor_running,
  input wire logic [31:0] total_travel,
  input wire logic [3:0] prediction_selection_saved,
  output logic [3:0] prediction_selection_setting,
  output logic friction_prediction_warning,
  output logic vibration_prediction_warning,
  output logic irq
);

  typedef struct packed {
    logic init_done;
    logic [1:0] fr_sel;
    logic [1:0] vb_sel;
    logic [3:0] travel_sel;
    logic [3:0] fr_mult;
    logic [3:0] vb_mult;
    logic [15:0] travel_limit;
    logic [15:0] fr_avg;
    logic [15:0] fr_std;
    logic [15:0] coef_one;
    logic [15:0] coef_two;
    logic [15:0] vb_avg;
    logic [15:0] vb_std;
    logic fr_warn;
    logic vb_warn;
    logic fr_learned;
    logic vb_learned;
    logic [5:0] irq_sts;
    logic [5:0] irq_mask;
    logic [31:0] prdata;
    logic pslverr;
    logic [39:0] hour_cnt;
    logic hour_tick;
  } main_state_t;

  main_state_t q;
  main_state_t d;

  learn_if fr_lk ();
  learn_if vb_lk ();

  logic signed [21:0] fr_upper;
  logic signed [21:0] fr_lower;
  logic signed [21:0] vb_upper;
  logic signed [21:0] vb_lower;
  logic signed [21:0] fr_est_s;
  logic signed [21:0] vb_lvl_s;
  logic [19:0] travel_span;
  logic travel_armed;
  logic not_torque;
  logic posvel;
  logic fr_active;
  logic vb_active;
  logic fr_outside;
  logic vb_outside;

  // ==========================================================
  // threshold bands
  // combinational from the stored settings
  limit_band u_fr_band (
    .average(q.fr_avg),
    .std_dev(q.fr_std),
    .mult(q.fr_mult),
    .upper(fr_upper),
    .lower(fr_lower)
  );

  limit_band u_vb_band (
    .average(q.vb_avg),
    .std_dev(q.vb_std),
    .mult(q.vb_mult),
    .upper(vb_upper),
    .lower(vb_lower)
  );

  // ==========================================================
  // learning hour counters
  learn_timer u_fr_timer (
    .pclk(pclk),
    .presetn(presetn),
    .lk(fr_lk)
  );

  learn_timer u_vb_timer (
    .pclk(pclk),
    .presetn(presetn),
    .lk(vb_lk)
  );

  // ==========================================================
  // operating conditions
  // a zero travel span arms on any nonzero total travel
  assign not_torque = (drive_mode != prediction_pkg::MODE_TORQUE);
  assign posvel = (drive_mode == prediction_pkg::MODE_POSITION) ||
                  (drive_mode == prediction_pkg::MODE_VELOCITY);
  assign travel_span = 20'(q.travel_sel) * 20'(q.travel_limit);
  assign travel_armed = total_travel > {13'h0000, travel_span[19:1]}; // [R03] [R06]
  assign fr_active = q.init_done && (q.fr_sel == prediction_pkg::SEL_MANUAL) &&
                     travel_armed && not_torque; // [R02] [R06]
  assign vb_active = q.init_done && (q.vb_sel == prediction_pkg::SEL_MANUAL) &&
                     not_torque; // [R02]
  assign fr_est_s = $signed({6'h00, friction_estimate});
  assign vb_lvl_s = $signed({6'h00, vibration_level});
  assign fr_outside = (fr_est_s > fr_upper) || (fr_est_s < fr_lower); // [R01] [R12]
  assign vb_outside = vb_lvl_s > vb_upper; // [R18]

  // learning counters: friction waits for the travel span, vibration does not
  // held cleared outside automatic mode
  assign fr_lk.hour_tick = q.hour_tick;
  assign fr_lk.running = motor_running;
  assign fr_lk.counting_mode = posvel;
  assign fr_lk.clear = !(q.fr_sel == prediction_pkg::SEL_AUTO && travel_armed); // [R03]
  assign vb_lk.hour_tick = q.hour_tick;
  assign vb_lk.running = motor_running;
  assign vb_lk.counting_mode = posvel;
  assign vb_lk.clear = (q.vb_sel != prediction_pkg::SEL_AUTO); // [R04]

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic [5:0] ev;
    logic [15:0] fr_dev;
    logic [15:0] vb_dev;
    rd = 32'h0000_0000;
    hit = 1'b1;
    ev = 6'h00;
    fr_dev = friction_estimate >> prediction_pkg::STD_SHIFT;
    vb_dev = vibration_level >> prediction_pkg::STD_SHIFT;
    if (fr_dev == 16'h0000) begin
      fr_dev = 16'h0001;
    end
    if (vb_dev == 16'h0000) begin
      vb_dev = 16'h0001;
    end
    d = q;
    d.hour_tick = 1'b0;

    // hour tick divider
    // one-cycle enable, the only hour time base
    if (q.hour_cnt == HOUR_CYCLES - 40'h1) begin
      d.hour_cnt = '0;
      d.hour_tick = 1'b1;
    end else begin
      d.hour_cnt = q.hour_cnt + 40'h1;
    end

    // power-up load of the saved selections; reset request turns into automatic
    if (!q.init_done) begin
      d.init_done = 1'b1;
      d.fr_sel = prediction_selection_saved[1:0];
      d.vb_sel = prediction_selection_saved[5 - 2:2];
      if (prediction_selection_saved[1:0] == prediction_pkg::SEL_RESET) begin
        d.fr_sel = prediction_pkg::SEL_AUTO; // [R14]
        d.fr_learned = 1'b0;
        d.fr_avg = prediction_pkg::SETTING_RESET;
        d.fr_std = prediction_pkg::SETTING_RESET;
      end
      if (prediction_selection_saved[3:2] == prediction_pkg::SEL_RESET) begin
        d.vb_sel = prediction_pkg::SEL_AUTO;
        d.vb_learned = 1'b0;
        d.vb_avg = prediction_pkg::SETTING_RESET;
        d.vb_std = prediction_pkg::SETTING_RESET;
      end
    end

    // register read mux
    // unmapped words read zero and raise pslverr
    unique case (paddr)
      prediction_pkg::OFS_CTRL: begin
        rd[prediction_pkg::CTRL_FR_SEL_LSB +: 2] = q.fr_sel;
        rd[prediction_pkg::CTRL_VB_SEL_LSB +: 2] = q.vb_sel;
        rd[prediction_pkg::CTRL_TRAVEL_SEL_LSB +: 4] = q.travel_sel;
      end
      prediction_pkg::OFS_MULT: begin
        rd[prediction_pkg::MULT_FR_LSB +: 4] = q.fr_mult;
        rd[prediction_pkg::MULT_VB_LSB +: 4] = q.vb_mult;
      end
      prediction_pkg::OFS_TRAVEL: rd[15:0] = q.travel_limit;
      prediction_pkg::OFS_FR_AVG: rd[15:0] = q.fr_avg;
      prediction_pkg::OFS_FR_STD: rd[15:0] = q.fr_std;
      prediction_pkg::OFS_COEF_ONE: rd[15:0] = q.coef_one;
      prediction_pkg::OFS_COEF_TWO: rd[15:0] = q.coef_two;
      prediction_pkg::OFS_VB_AVG: rd[15:0] = q.vb_avg;
      prediction_pkg::OFS_VB_STD: rd[15:0] = q.vb_std;
      prediction_pkg::OFS_STATUS: begin
        rd[4:0] = {travel_armed, q.vb_learned, q.fr_learned, q.vb_warn, q.fr_warn}; // [R19]
      end
      prediction_pkg::OFS_IRQ_STS: rd[5:0] = q.irq_sts;
      prediction_pkg::OFS_IRQ_MASK: rd[5:0] = q.irq_mask;
      prediction_pkg::OFS_FR_UPPER: rd = 32'(fr_upper); // [R10]
      prediction_pkg::OFS_FR_LOWER: rd = 32'(fr_lower);
      prediction_pkg::OFS_VB_UPPER: rd = 32'(vb_upper);
      default: hit = 1'b0;
    endcase

    // setup phase captures read data and the error flag
    // pready is tied high, so this is what the access phase shows
    if (psel && !penable) begin
      d.prdata = pwrite ? 32'h0000_0000 : rd;
      d.pslverr = !hit;
    end

    // access phase write
    if (psel && penable && pwrite && hit) begin
      unique case (paddr)
        prediction_pkg::OFS_CTRL: begin
          d.fr_sel = pwdata[prediction_pkg::CTRL_FR_SEL_LSB +: 2]; // [R07]
          d.vb_sel = pwdata[prediction_pkg::CTRL_VB_SEL_LSB +: 2];
          d.travel_sel = pwdata[prediction_pkg::CTRL_TRAVEL_SEL_LSB +: 4];
        end
        prediction_pkg::OFS_MULT: begin
          d.fr_mult = pwdata[prediction_pkg::MULT_FR_LSB +: 4];
          d.vb_mult = pwdata[prediction_pkg::MULT_VB_LSB +: 4];
        end
        prediction_pkg::OFS_TRAVEL: d.travel_limit = pwdata[15:0];
        prediction_pkg::OFS_FR_AVG: d.fr_avg = pwdata[15:0];
        prediction_pkg::OFS_FR_STD: d.fr_std = pwdata[15:0];
        prediction_pkg::OFS_COEF_ONE: d.coef_one = pwdata[15:0];
        prediction_pkg::OFS_COEF_TWO: d.coef_two = pwdata[15:0];
        prediction_pkg::OFS_VB_AVG: d.vb_avg = pwdata[15:0];
        prediction_pkg::OFS_VB_STD: d.vb_std = pwdata[15:0];
        prediction_pkg::OFS_IRQ_STS: d.irq_sts = q.irq_sts & ~pwdata[5:0];
        prediction_pkg::OFS_IRQ_MASK: d.irq_mask = pwdata[5:0];
        default: d.prdata = q.prdata; // read-only words ignore writes
      endcase
    end

    // friction threshold learning overrides a same-cycle software write
    if (q.init_done && q.fr_sel == prediction_pkg::SEL_AUTO && fr_lk.ready &&
        friction_estimate_valid && not_torque) begin
      d.fr_avg = friction_estimate; // [R08]
      d.fr_std = fr_dev;
      d.fr_sel = prediction_pkg::SEL_MANUAL; // [R09]
      d.fr_learned = 1'b1;
      ev[prediction_pkg::IRQ_FR_LEARNED] = 1'b1;
    end

    // vibration threshold learning
    if (q.init_done && q.vb_sel == prediction_pkg::SEL_AUTO && vb_lk.ready &&
        vibration_level_valid && not_torque) begin
      d.vb_avg = vibration_level; // [R04]
      d.vb_std = vb_dev;
      d.vb_sel = prediction_pkg::SEL_MANUAL;
      d.vb_learned = 1'b1;
      ev[prediction_pkg::IRQ_VB_LEARNED] = 1'b1;
    end

    // friction warning: only in manual, held through torque mode
    // the held verdict stays readable while prediction is paused
    if (q.fr_sel != prediction_pkg::SEL_MANUAL) begin
      d.fr_warn = 1'b0; // [R05]
    end else if (fr_active && friction_estimate_valid) begin
      d.fr_warn = fr_outside; // [R12] [R13]
    end

    // vibration warning
    // vibration has no lower edge, only the upper one
    if (q.vb_sel != prediction_pkg::SEL_MANUAL) begin
      d.vb_warn = 1'b0;
    end else if (vb_active && vibration_level_valid) begin
      d.vb_warn = vb_outside; // [R18]
    end

    // warning edges raise sticky events, set wins over clear
    ev[prediction_pkg::IRQ_FR_SET] = d.fr_warn && !q.fr_warn;
    ev[prediction_pkg::IRQ_FR_CLR] = !d.fr_warn && q.fr_warn;
    ev[prediction_pkg::IRQ_VB_SET] = d.vb_warn && !q.vb_warn;
    ev[prediction_pkg::IRQ_VB_CLR] = !d.vb_warn && q.vb_warn;
    d.irq_sts = d.irq_sts | ev;
  end

  // ==========================================================
  // state register
  // settings come up zero; saved selections load one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.fr_mult <= 4'h0;
      q.vb_mult <= 4'h0;
      q.fr_avg <= prediction_pkg::SETTING_RESET;
      q.fr_std <= prediction_pkg::SETTING_RESET;
      q.vb_avg <= prediction_pkg::SETTING_RESET;
      q.vb_std <= prediction_pkg::SETTING_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  // irq is a level built from registers only
  assign prdata = q.prdata;
  assign pready = 1'b1; // every access completes in one access cycle
  assign pslverr = q.pslverr;
  assign prediction_selection_setting = {q.vb_sel, q.fr_sel};
  assign friction_prediction_warning = q.fr_warn; // [R19]
  assign vibration_prediction_warning = q.vb_warn;
  assign irq = |(q.irq_sts & q.irq_mask);

endmodule : friction_failure_predictor

// ==== verification/predictor_chk.sv ====
// assertion checker for the friction failure predictor ports
module predictor_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic friction_estimate_valid,
  input wire logic vibration_level_valid,
  input wire prediction_pkg::drive_mode_t drive_mode,
  input wire logic [3:0] prediction_selection_saved,
  input wire logic [3:0] prediction_selection_setting,
  input wire logic friction_prediction_warning,
  input wire logic vibration_prediction_warning,
  input wire logic irq
);
  // ==========================================================
  // helper logic
  logic [1:0] boot_q;
  logic wr;
  logic [1:0] fsel;
  logic [3:0] sv;
  logic fw;
  logic vw;
  logic fv;
  logic vv;
  logic torque;
  // short aliases for the watched ports
  assign wr = psel && penable && pwrite;
  assign fsel = prediction_selection_setting[1:0];
  assign sv = prediction_selection_saved;
  assign fw = friction_prediction_warning;
  assign vw = vibration_prediction_warning;
  assign fv = friction_estimate_valid;
  assign vv = vibration_level_valid;
  assign torque = drive_mode == prediction_pkg::MODE_TORQUE;
  // edges since reset release, saturating at 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 2'h0;
    end else if (boot_q != 2'h2) begin
      boot_q <= boot_q + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // properties
  property p_torque_fr;
    fv && torque && !wr && fsel == 2'h2 |=> $stable(fw);
  endproperty
  a_torque_fr: assert property (p_torque_fr) else $error("friction warning moved in torque mode");
  property p_torque_vb;
    vv && torque && !wr && prediction_selection_setting[3:2] == 2'h2 |=> $stable(vw);
  endproperty
  a_torque_vb: assert property (p_torque_vb) else $error("vibration warning moved in torque mode");
  property p_fr_idle;
    (fsel != 2'h2) [*2] |-> !fw;
  endproperty
  a_fr_idle: assert property (p_fr_idle) else $error("friction warning outside manual mode");
  property p_fr_cause;
    $changed(fw) |-> $past(fv) || $past(fsel) != 2'h2 || fsel != 2'h2;
  endproperty
  a_fr_cause: assert property (p_fr_cause) else $error("friction warning changed without sample");
  property p_vb_cause;
    $rose(vw) |-> $past(vv) && !$past(torque);
  endproperty
  a_vb_cause: assert property (p_vb_cause) else $error("vibration warning rose without sample");
  property p_learn;
    fsel == 2'h2 && $past(fsel) == 2'h1 |-> $past(fv) || $past(wr);
  endproperty
  a_learn: assert property (p_learn) else $error("selection went manual without learning");
  property p_boot;
    boot_q == 2'h1 |-> prediction_selection_setting ==
      {(sv[3:2] == 2'h3) ? 2'h1 : sv[3:2], (sv[1:0] == 2'h3) ? 2'h1 : sv[1:0]};
  endproperty
  a_boot: assert property (p_boot) else $error("selection not loaded at power up");
  property p_irq;
    $rose(irq) |-> $changed(fw) || $changed(vw) || $past(fv) || $past(vv) || $past(wr);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt rose without event");
  property p_err;
    psel && penable && paddr > 8'h38 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access without error");
  // main scenarios
  c_fw: cover property ($rose(fw));
  c_vw: cover property ($rose(vw));
  c_learn: cover property (fsel == 2'h2 && $past(fsel) == 2'h1 && $past(fv));
  c_boot: cover property (boot_q == 2'h1 && sv[1:0] == 2'h3);
endmodule : predictor_chk

bind friction_failure_predictor predictor_chk u_predictor_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pslverr, .friction_estimate_valid, .vibration_level_valid,
  .drive_mode, .prediction_selection_saved, .prediction_selection_setting,
  .friction_prediction_warning, .vibration_prediction_warning, .irq);

// ==== verification/tb_top.sv ====
// self-checking testbench for the friction failure predictor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, fv, vv, run, fw, vw, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, tt, rd;
  logic [15:0] fe, vl;
  logic [3:0] saved, sel_o;
  prediction_pkg::drive_mode_t mode;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h799a1a2f;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  friction_failure_predictor #(.HOUR_CYCLES(40'h8)) u_friction_failure_predictor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .friction_estimate(fe), .friction_estimate_valid(fv), .vibration_level(vl),
    .vibration_level_valid(vv), .drive_mode(mode), .motor_running(run), .total_travel(tt),
    .prediction_selection_saved(saved), .prediction_selection_setting(sel_o),
    .friction_prediction_warning(fw), .vibration_prediction_warning(vw), .irq(irq));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic mwarn(input int e, input int avg, input int sd, input int m);
    int k;
    k = (m == 0) ? 5 : m;
    return (e > avg + sd * k) || (e < avg - sd * k);
  endfunction : mwarn
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  // one estimator sample, warning settled on return
  task automatic est(input logic f, input logic [15:0] v);
    if (f) begin
      fe <= v;
      fv <= 1'b1;
    end else begin
      vl <= v;
      vv <= 1'b1;
    end
    @(posedge pclk);
    fv <= 1'b0;
    vv <= 1'b0;
    @(posedge pclk);
  endtask : est
  // ==========================================================
  // watchdog
  initial begin
    repeat (4000) @(posedge pclk);
    err_total++;
    results();
  end
  // main sequence
  initial begin
    int q[$];
    logic [15:0] v;
    q = '{1100, 1101, 1000, 900, 899, 1000};
    {psel, penable, pwrite, fv, vv, run} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fe = 16'h0;
    vl = 16'h0;
    tt = 32'h64;
    saved = 4'h0;
    mode = prediction_pkg::MODE_POSITION;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int a = 0; a <= 'h38; a += 4) begin
      // a zero travel span at reset leaves the armed flag set
      rchk("reset value", 8'(a), {27'h0, (8'(a) == prediction_pkg::OFS_STATUS), 4'h0});
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, prediction_pkg::OFS_FR_AVG, 32'd1000);
    apb(1'b1, prediction_pkg::OFS_FR_STD, 32'd20);
    apb(1'b1, prediction_pkg::OFS_TRAVEL, 32'd100);
    apb(1'b1, prediction_pkg::OFS_CTRL, 32'h202);
    rchk("upper limit", prediction_pkg::OFS_FR_UPPER, 32'd1100);
    rchk("lower limit", prediction_pkg::OFS_FR_LOWER, 32'd900);
    est(1'b1, 16'd1200);
    chk("unarmed warning", {31'h0, fw}, 32'h0);
    tt <= 32'h65;
    repeat (2) @(posedge pclk);
    foreach (q[i]) begin
      est(1'b1, q[i][15:0]);
      chk("band warning", {31'h0, fw}, {31'h0, mwarn(q[i], 1000, 20, 0)});
    end
    rchk("irq status", prediction_pkg::OFS_IRQ_STS, 32'h3);
    chk("masked irq", {31'h0, irq}, 32'h0);
    apb(1'b1, prediction_pkg::OFS_IRQ_MASK, 32'h1);
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    apb(1'b1, prediction_pkg::OFS_IRQ_STS, 32'h1);
    chk("cleared irq", {31'h0, irq}, 32'h0);
    apb(1'b1, prediction_pkg::OFS_MULT, 32'h7);
    rchk("upper limit", prediction_pkg::OFS_FR_UPPER, 32'd1140);
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      v = 16'(800 + seed % 400);
      est(1'b1, v);
      chk("random warning", {31'h0, fw}, {31'h0, mwarn(v, 1000, 20, 7)});
    end
    est(1'b1, 16'd1000);
    mode <= prediction_pkg::MODE_TORQUE;
    est(1'b1, 16'd2000);
    chk("torque warning", {31'h0, fw}, 32'h0);
    mode <= prediction_pkg::MODE_VELOCITY;
    apb(1'b1, prediction_pkg::OFS_VB_AVG, 32'd500);
    apb(1'b1, prediction_pkg::OFS_VB_STD, 32'd10);
    apb(1'b1, prediction_pkg::OFS_CTRL, 32'h222);
    rchk("vibration limit", prediction_pkg::OFS_VB_UPPER, 32'd550);
    est(1'b0, 16'd551);
    chk("vibration warning", {31'h0, vw}, 32'h1);
    chk("separate flags", {31'h0, fw}, 32'h0);
    est(1'b0, 16'd550);
    chk("vibration warning", {31'h0, vw}, 32'h0);
    apb(1'b1, prediction_pkg::OFS_CTRL, 32'h201);
    run <= 1'b1;
    repeat (600) @(posedge pclk);
    est(1'b1, 16'd5000);
    chk("early auto warning", {31'h0, fw}, 32'h0);
    rchk("selection learning", prediction_pkg::OFS_CTRL, 32'h201);
    repeat (200) @(posedge pclk);
    est(1'b1, 16'd800);
    rchk("selection learned", prediction_pkg::OFS_CTRL, 32'h202);
    chk("saved selection", {28'h0, sel_o}, 32'h2);
    rchk("learned average", prediction_pkg::OFS_FR_AVG, 32'd800);
    rchk("learned deviation", prediction_pkg::OFS_FR_STD, 32'd25);
    apb(1'b1, prediction_pkg::OFS_COEF_ONE, 32'd800);
    apb(1'b1, prediction_pkg::OFS_COEF_TWO, 32'd25);
    rchk("coefficient one", prediction_pkg::OFS_COEF_ONE, 32'd800);
    rchk("coefficient two", prediction_pkg::OFS_COEF_TWO, 32'd25);
    est(1'b1, 16'd976);
    chk("learned warning", {31'h0, fw}, 32'h1);
    saved <= 4'hf;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("reset selection", {28'h0, sel_o}, 32'h5);
    rchk("cleared average", prediction_pkg::OFS_FR_AVG, 32'h0);
    results();
  end
endmodule : tb_top
